// ===== hdl/gpio_pkg.sv
// Constants shared by the shared parallel I/O port design.
package gpio_pkg;

    // ------------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------------
    // Number of pin positions that the port decodes.
    localparam int PORT_W = 16;
    // Pins that really exist on this device; the rest read as zero.
    localparam logic [15:0] IMPL_MASK = 16'hffff;
    // Pins that are shared with an analog input.
    localparam logic [15:0] ANALOG_MASK = 16'h00ff;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_DIRECTION = 12'h000;
    localparam logic [11:0] OFS_PIN_STATE = 12'h004;
    localparam logic [11:0] OFS_OUT_LATCH = 12'h008;
    localparam logic [11:0] OFS_OPEN_DRAIN = 12'h00c;
    localparam logic [11:0] OFS_ANALOG_SEL = 12'h010;
    localparam logic [11:0] OFS_PULL_UP = 12'h014;
    localparam logic [11:0] OFS_PULL_DOWN = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h01c;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    // All ones: every pin is an input after reset.
    localparam logic [15:0] RST_DIRECTION = 16'hffff;
    localparam logic [15:0] RST_OUT_LATCH = 16'h0000;
    localparam logic [15:0] RST_OPEN_DRAIN = 16'h0000;
    // Analog-capable pins start in analog mode.
    localparam logic [15:0] RST_ANALOG_SEL = ANALOG_MASK;
    localparam logic [15:0] RST_PULL_UP = 16'h0000;
    localparam logic [15:0] RST_PULL_DOWN = 16'h0000;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    // Bit holding the synchronised over-voltage level.
    localparam int ST_OVERVOLT_BIT = 0;
    // Lowest bit of the peripheral ownership field.
    localparam int ST_OWNER_LSB = 16;

endpackage : gpio_pkg

// ===== hdl/sync2.sv
// Two-flop synchroniser for levels that enter from outside the clock.
`timescale 1ns/1ps

module sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage; read by the second stage only.
    logic [W-1:0] meta_r;

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    // Both stages clear on reset so that nothing unknown leaks out.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : sync2

// ===== hdl/shared_parallel_io_port.sv
// Shared parallel I/O port with APB registers and pin multiplexing.
//
// Functional notes
// - Active peripheral drive disables port driver; pin readable.
// - Enabled but idle peripheral lets port drive.
// - Per-pin data and enable muxes, peripheral first.
// - Port output never loops into peripheral input.
// - Direction bit one is input, zero output.
// - Reset returns every direction bit to input.
// - Latch register reads and writes the latch; analog pins read zero.
// - Pin-state reads pins; writes go to latch.
// - Unimplemented bits read zero in all registers.
// - Port offers eight digital I/O registers.
// - Input-only shared function leaves port owning pin.
// - Over-voltage detect tristates every pin while present.
// - Analog pins reset analog; digital reads return zero.
// - Per-pin weak pull-up and pull-down enables.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps

module shared_parallel_io_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral side, same clock domain.
    input wire logic [15:0] periph_enable,
    input wire logic [15:0] periph_drive,
    input wire logic [15:0] periph_out,
    output logic [15:0] periph_in,
    // Supply monitor, asynchronous level.
    input wire logic core_overvoltage_detect,
    // Package pins.
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic [15:0] pull_up_en,
    output logic [15:0] pull_down_en,
    output logic [15:0] input_buf_en
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Software-visible storage.
    logic [15:0] direction_r;
    logic [15:0] out_latch_r;
    logic [15:0] open_drain_r;
    logic [15:0] analog_sel_r;
    logic [15:0] pull_up_r;
    logic [15:0] pull_down_r;
    // Synchronised pin levels and over-voltage level.
    logic [15:0] pin_sync;
    logic [0:0] ovd_sync;
    // Bus handshake state.
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    // Decoded bus events.
    logic setup_cyc;
    logic wr_take;
    logic [15:0] wr_mask;
    logic [15:0] wr_data;
    logic addr_ok;
    logic [31:0] rd_nxt;
    // Ownership and next pin values.
    logic [15:0] periph_owns;
    logic [15:0] port_oe;
    logic [15:0] digital_in;
    logic [15:0] pin_out_nxt;
    logic [15:0] pin_oe_nxt;
    logic [15:0] periph_in_nxt;
    // Registered pin-side outputs.
    logic [15:0] pin_out_r;
    logic [15:0] pin_oe_r;
    logic [15:0] periph_in_r;
    logic [15:0] pull_up_out_r;
    logic [15:0] pull_down_out_r;
    logic [15:0] in_buf_r;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Pins are asynchronous to clk, so nothing reads them raw.
    sync2 #(
        .W(16)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d(pin_in),
        .q(pin_sync)
    );

    // The supply monitor is also asynchronous to clk.
    sync2 #(
        .W(1)
    ) u_ovd_sync (
        .clk(clk),
        .rst(rst),
        .d(core_overvoltage_detect),
        .q(ovd_sync)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Setup phase of a new transfer.
    assign setup_cyc = psel && !penable;
    // A write lands only on the edge where pready is sampled high.
    assign wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
    // Byte lanes 0 and 1 carry the 16 register bits.
    assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & gpio_pkg::IMPL_MASK;
    assign wr_data = pwdata[15:0];

    // Digital input level as seen by software; analog pins read zero.
    assign digital_in = pin_sync & ~analog_sel_r & gpio_pkg::IMPL_MASK;

    // Read mux, evaluated in the setup phase and held in prdata_r.
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            gpio_pkg::OFS_DIRECTION:
            begin
                rd_nxt[15:0] = direction_r & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_PIN_STATE:
            begin
                // Real pin levels, not the latch.
                rd_nxt[15:0] = digital_in;
            end
            gpio_pkg::OFS_OUT_LATCH:
            begin
                // Latch contents, masked for analog and absent pins.
                rd_nxt[15:0] = out_latch_r & ~analog_sel_r
                    & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_OPEN_DRAIN:
            begin
                rd_nxt[15:0] = open_drain_r & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_ANALOG_SEL:
            begin
                rd_nxt[15:0] = analog_sel_r & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_PULL_UP:
            begin
                rd_nxt[15:0] = pull_up_r & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_PULL_DOWN:
            begin
                rd_nxt[15:0] = pull_down_r & gpio_pkg::IMPL_MASK;
            end
            gpio_pkg::OFS_STATUS:
            begin
                // Over-voltage level and which pins a peripheral owns.
                rd_nxt[gpio_pkg::ST_OVERVOLT_BIT] = ovd_sync[0];
                rd_nxt[gpio_pkg::ST_OWNER_LSB +: 16] = periph_owns;
            end
            default:
            begin
                // Unmapped words read zero and flag an error.
                addr_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // One wait-free access phase: pready rises in the cycle after
    // setup and falls again after it, so every transfer takes two
    // cycles and back-to-back transfers are allowed.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (setup_cyc)
        begin
            pready_r <= 1'b1;
            pslverr_r <= !addr_ok;
            // Writes return zero data to keep the bus quiet.
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------------
    // Every reset restores all ones so all pins start as inputs.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            direction_r <= gpio_pkg::RST_DIRECTION;
        end
        else if (wr_take && paddr == gpio_pkg::OFS_DIRECTION)
        begin
            direction_r <= (direction_r & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // ------------------------------------------------------------------
    // Output latch
    // ------------------------------------------------------------------
    // The latch is written through its own offset and also through
    // the pin-state offset, which has no storage of its own.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_latch_r <= gpio_pkg::RST_OUT_LATCH;
        end
        else if (wr_take && (paddr == gpio_pkg::OFS_OUT_LATCH
            || paddr == gpio_pkg::OFS_PIN_STATE))
        begin
            out_latch_r <= (out_latch_r & ~wr_mask)
                | (wr_data & wr_mask);
        end
    end

    // ------------------------------------------------------------------
    // Open-drain register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            open_drain_r <= gpio_pkg::RST_OPEN_DRAIN;
        end
        else if (wr_take && paddr == gpio_pkg::OFS_OPEN_DRAIN)
        begin
            open_drain_r <= (open_drain_r & ~wr_mask)
                | (wr_data & wr_mask);
        end
    end

    // ------------------------------------------------------------------
    // Analog select register
    // ------------------------------------------------------------------
    // Only analog-capable pins may hold a one here; software must
    // clear a bit before using that pin as a digital input.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            analog_sel_r <= gpio_pkg::RST_ANALOG_SEL;
        end
        else if (wr_take && paddr == gpio_pkg::OFS_ANALOG_SEL)
        begin
            analog_sel_r <= ((analog_sel_r & ~wr_mask)
                | (wr_data & wr_mask)) & gpio_pkg::ANALOG_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Pull resistor enables
    // ------------------------------------------------------------------
    // Pull-up enables, one bit per pin.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pull_up_r <= gpio_pkg::RST_PULL_UP;
        end
        else if (wr_take && paddr == gpio_pkg::OFS_PULL_UP)
        begin
            pull_up_r <= (pull_up_r & ~wr_mask)
                | (wr_data & wr_mask);
        end
    end

    // Pull-down enables, one bit per pin.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pull_down_r <= gpio_pkg::RST_PULL_DOWN;
        end
        else if (wr_take && paddr == gpio_pkg::OFS_PULL_DOWN)
        begin
            pull_down_r <= (pull_down_r & ~wr_mask)
                | (wr_data & wr_mask);
        end
    end

    // ------------------------------------------------------------------
    // Pin multiplexers
    // ------------------------------------------------------------------
    // A peripheral owns a pin only while enabled and actively driving.
    // An input-only function never raises periph_drive, so the port
    // keeps such a pin as if it were dedicated.
    assign periph_owns = periph_enable & periph_drive
        & gpio_pkg::IMPL_MASK;

    // Port drive: direction zero means output; open drain only pulls
    // low and releases the pin for a one.
    assign port_oe = ~direction_r & ~(open_drain_r & out_latch_r)
        & gpio_pkg::IMPL_MASK;

    // Data and enable muxes, the peripheral taking precedence.
    always_comb
    begin
        pin_out_nxt = (periph_owns & periph_out)
            | (~periph_owns & out_latch_r & ~open_drain_r);
        pin_oe_nxt = periph_owns | (~periph_owns & port_oe);
        // Over-voltage tristates every pin for as long as it lasts.
        if (ovd_sync[0])
        begin
            pin_oe_nxt = 16'h0000;
        end
        // A pin the port itself drives gives the peripheral zero, so
        // the port's output never loops into the peripheral input.
        periph_in_nxt = digital_in & ~(~periph_owns & port_oe);
    end

    // ------------------------------------------------------------------
    // Pin-side output registers
    // ------------------------------------------------------------------
    // Registering costs one cycle of latency but keeps the pads free
    // of glitches from the multiplexers.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_out_r <= 16'h0000;
            pin_oe_r <= 16'h0000;
        end
        else
        begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    // Loop-free input towards the peripherals.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            periph_in_r <= 16'h0000;
        end
        else
        begin
            periph_in_r <= periph_in_nxt;
        end
    end

    // Pulls and input buffers go off during over-voltage as well.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pull_up_out_r <= 16'h0000;
            pull_down_out_r <= 16'h0000;
            in_buf_r <= 16'h0000;
        end
        else if (ovd_sync[0])
        begin
            pull_up_out_r <= 16'h0000;
            pull_down_out_r <= 16'h0000;
            in_buf_r <= 16'h0000;
        end
        else
        begin
            pull_up_out_r <= pull_up_r & gpio_pkg::IMPL_MASK;
            pull_down_out_r <= pull_down_r & gpio_pkg::IMPL_MASK;
            // Analog mode disables the digital input buffer.
            in_buf_r <= ~analog_sel_r & gpio_pkg::IMPL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign periph_in = periph_in_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pull_up_en = pull_up_out_r;
    assign pull_down_en = pull_down_out_r;
    assign input_buf_en = in_buf_r;

endmodule : shared_parallel_io_port

// ===== test/pin_world.sv
// Model of the circuitry that sits outside the package pins.
`timescale 1ns/1ps

module pin_world (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pads from the port.
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en,
    input wire logic [15:0] pull_down_en,
    // Outside driver set by the bench.
    input wire logic [15:0] ext_drive,
    input wire logic [15:0] ext_level,
    // Level seen on each pin.
    output logic [15:0] pin_in
);
    // Undriven, unpulled pins toggle so that no stale level passes.
    logic [15:0] float_r;

    // ------------------------------------------------------------
    // Floating pattern
    // ------------------------------------------------------------
    // The pattern changes every cycle, as a real open pin would.
    always_ff @(posedge clk or posedge rst)
        if (rst)
            float_r <= 16'h5555;
        else
            float_r <= ~float_r;

    // The port driver wins, then the outside driver, then the pulls.
    assign pin_in = (pin_oe & pin_out)
        | (~pin_oe & ext_drive & ext_level)
        | (~pin_oe & ~ext_drive & (pull_up_en | (~pull_down_en & float_r)));
endmodule : pin_world

// ===== test/gpio_chk.sv
// Assertion checker for the shared parallel I/O port.
`timescale 1ns/1ps

module gpio_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Peripheral, monitor and pins.
    input wire logic [15:0] periph_enable,
    input wire logic [15:0] periph_drive,
    input wire logic [15:0] periph_out,
    input wire logic core_overvoltage_detect,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en
);
    // Pins that the peripherals claim.
    logic [15:0] claim;
    // Cycles since the monitor was last high, saturating at seven.
    logic [2:0] quiet_r;

    assign claim = periph_enable & periph_drive;

    // ------------------------------------------------------------
    // Quiet counter
    // ------------------------------------------------------------
    // Pin checks wait until the synchroniser has surely drained.
    always_ff @(posedge clk or posedge rst)
        if (rst)
            quiet_r <= 3'h0;
        else if (core_overvoltage_detect)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_ready_setup: assert property (
        (psel && !penable) |=> pready)
        else $error("ready missing after setup");
    a_ready_cause: assert property (
        pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error outside ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    a_unmapped_err: assert property (
        (psel && !penable && paddr > 12'h01c) |=> pslverr)
        else $error("unmapped access not refused");
    a_ovp_tristate: assert property (
        core_overvoltage_detect [*3]
        |=> (pin_oe == 16'h0 && pull_up_en == 16'h0))
        else $error("pins driven under over-voltage");
    a_periph_data: assert property (
        (quiet_r == 3'h7 && |claim)
        |=> ((pin_out ^ $past(periph_out)) & $past(claim)) == 16'h0)
        else $error("peripheral data not on pin");
    a_periph_oe: assert property (
        (quiet_r == 3'h7 && |claim)
        |=> (~pin_oe & $past(claim)) == 16'h0)
        else $error("peripheral pin not driven");
    a_dir_oe: assert property (
        (quiet_r == 3'h7 && claim == 16'h0 && psel && penable && pready
        && pwrite && paddr == 12'h000 && pstrb == 4'hf)
        |-> ##2 (pin_oe == ~$past(pwdata[15:0], 2)))
        else $error("direction not applied");

    // Main scenarios reached.
    c_refused: cover property (pslverr);
    c_ovp: cover property (core_overvoltage_detect [*3]);
    c_claim: cover property (|claim);
endmodule : gpio_chk

bind shared_parallel_io_port gpio_chk gpio_chk_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_enable(periph_enable), .periph_drive(periph_drive),
    .periph_out(periph_out),
    .core_overvoltage_detect(core_overvoltage_detect),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en)
);

// ===== test/test_shared_parallel_io_port.sv
// Self-checking testbench for the shared parallel I/O port.
`timescale 1ns/1ps

module test_shared_parallel_io_port;
    // Design and model wiring.
    logic clk, rst, psel, penable, pwrite, pready, pslverr, ovp, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [15:0] p_en, p_drv, p_out, periph_in, pin_in, pin_out, pin_oe;
    logic [15:0] pu_en, pd_en, ibuf_en, ext_drive, ext_level;
    int num_errors = 0;
    int checks = 0;
    // Register values expected straight after reset, offset order.
    logic [31:0] rst_exp [8] = '{32'h0000ffff, 32'h00003c00, 32'h0,
        32'h0, 32'h000000ff, 32'h0, 32'h0, 32'h0};

    shared_parallel_io_port shared_parallel_io_port_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_enable(p_en), .periph_drive(p_drv), .periph_out(p_out),
        .periph_in(periph_in), .core_overvoltage_detect(ovp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pu_en), .pull_down_en(pd_en), .input_buf_en(ibuf_en));

    pin_world pin_world_i (
        .clk(clk), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_en(pu_en), .pull_down_en(pd_en), .ext_drive(ext_drive),
        .ext_level(ext_level), .pin_in(pin_in));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // One APB transfer; the wait is bounded so a silent slave fails.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            num_errors++;
            finish_test;
        end
    endtask : apb

    // Upper data bits are set to show that they are ignored.
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] rd;
        apb(1'b1, a, {16'hffff, d}, rd);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        apb(1'b0, a, 32'h0, rd);
        cmp(rd, exp);
    endtask : rd_chk

    // Lets synchroniser and output registers catch up.
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle

    task automatic finish_test;
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // The tests need well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test;
    end

    initial
    begin
        {rst, psel, penable, pwrite, ovp, last_err} = 6'b100000;
        {paddr, pwdata, pstrb} = {12'h0, 32'h0, 4'hf};
        {p_en, p_drv, p_out, ext_drive} = {16'h0, 16'h0, 16'h0, 16'hffff};
        ext_level = 16'h3c3c;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        settle;
        cmp(pin_oe, 32'h0);
        cmp(ibuf_en, 32'hff00);
        for (int i = 0; i < 8; i++)
            rd_chk(12'(i * 4), rst_exp[i]);
        wr(12'h020, 16'h0000);
        cmp(last_err, 32'h1);
        rd_chk(gpio_pkg::OFS_DIRECTION, 32'h0000ffff);
        // Software leaves analog mode before digital use.
        wr(gpio_pkg::OFS_ANALOG_SEL, 16'h0000);
        settle;
        cmp(periph_in, 32'h3c3c);
        rd_chk(gpio_pkg::OFS_PIN_STATE, 32'h00003c3c);
        wr(gpio_pkg::OFS_PIN_STATE, 16'ha5a5);
        rd_chk(gpio_pkg::OFS_OUT_LATCH, 32'h0000a5a5);
        // Byte lanes: only the strobed half of the latch changes.
        pstrb <= 4'h2;
        wr(gpio_pkg::OFS_OUT_LATCH, 16'h12ff);
        rd_chk(gpio_pkg::OFS_OUT_LATCH, 32'h000012a5);
        pstrb <= 4'h1;
        wr(gpio_pkg::OFS_OUT_LATCH, 16'hff34);
        pstrb <= 4'hf;
        rd_chk(gpio_pkg::OFS_OUT_LATCH, 32'h00001234);
        wr(gpio_pkg::OFS_DIRECTION, 16'h0000);
        settle;
        cmp({pin_oe, pin_out}, 32'hffff1234);
        cmp(periph_in, 32'h0);
        // Open drain releases the pin for a one and drives a zero.
        wr(gpio_pkg::OFS_OPEN_DRAIN, 16'h00ff);
        settle;
        cmp({pin_oe, pin_out}, 32'hffcb1200);
        rd_chk(gpio_pkg::OFS_OPEN_DRAIN, 32'h000000ff);
        wr(gpio_pkg::OFS_OPEN_DRAIN, 16'h0000);
        // Pins 7:4 claimed, the rest enabled but idle.
        p_en <= 16'hffff;
        p_drv <= 16'h00f0;
        p_out <= 16'hffc0;
        settle;
        cmp({pin_oe, pin_out}, 32'hffff12c4);
        rd_chk(gpio_pkg::OFS_PIN_STATE, 32'h000012c4);
        rd_chk(gpio_pkg::OFS_STATUS, 32'h00f00000);
        p_drv <= 16'h0000;
        ovp <= 1'b1;
        wr(gpio_pkg::OFS_PULL_UP, 16'h00ff);
        settle;
        cmp({pin_oe, pu_en}, 32'h0);
        rd_chk(gpio_pkg::OFS_STATUS, 32'h00000001);
        ovp <= 1'b0;
        settle;
        cmp({pin_oe, pu_en}, 32'hffff00ff);
        // Release the pins so only the pulls hold them.
        wr(gpio_pkg::OFS_PULL_DOWN, 16'hff00);
        wr(gpio_pkg::OFS_DIRECTION, 16'hffff);
        ext_drive <= 16'h0000;
        settle;
        cmp(pd_en, 32'hff00);
        rd_chk(gpio_pkg::OFS_PIN_STATE, 32'h000000ff);
        wr(gpio_pkg::OFS_ANALOG_SEL, 16'hffff);
        settle;
        cmp(ibuf_en, 32'hff00);
        rd_chk(gpio_pkg::OFS_PIN_STATE, 32'h0);
        rd_chk(gpio_pkg::OFS_OUT_LATCH, 32'h00001200);
        // A second reset in mid-run.
        wr(gpio_pkg::OFS_DIRECTION, 16'h0f0f);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle;
        cmp(pin_oe, 32'h0);
        rd_chk(gpio_pkg::OFS_DIRECTION, 32'h0000ffff);
        finish_test;
    end
endmodule : test_shared_parallel_io_port
